/* rtl/ubs_pkg.sv */
// Constants for the break and synchronous serial block
// Function
// - Break is start, twelve zeros, stop
// - Break armed: holding write sends zeros only
// - Hardware clears break request after stop bit
// - Received break: pending, framing error, zero
// - Wake-up watches two edges, then next byte
// - Synchronous: no start/stop, half-duplex only
// - Mode bits select sync, master, direction, enable
// - Master drives clock, one cycle per bit
// - Data changes on leading clock edge
// - Polarity bit sets clock idle level
// - Holding waits, then moves to shifter at once
// - Master transmit drives data and clock pins
// - Master receive releases the data pin
// - Single receive: one character, then self-clears
// - Continuous clocks; clearing aborts partial character
// - Both set: single clears, continuous continues
// - Sample on trailing edge, push into FIFO
// - Data shows oldest entry; pending while unread
// - Slave takes external clock, driver off
// - Third character on full FIFO sets overrun
// - Overrun clear: read if single, else disable
// - Nine-bit receive; ninth bit read first
// - Rising edge ending break clears wake enable
package ubs_pkg;
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  localparam int CTRL_W = 12;
  localparam int B_PEN = 0;
  localparam int B_SYNC = 1;
  localparam int B_MASTER = 2;
  localparam int B_TRANSMIT_ENABLE_BIT = 3;
  localparam int B_SEND_BREAK_REQ = 4;
  localparam int B_SINGLE = 5;
  localparam int B_CONT = 6;
  localparam int B_POL = 7;
  localparam int B_RX9 = 8;
  localparam int B_TX9 = 9;
  localparam int B_TX_NINTH_BIT = 10;
  localparam int B_WAKE = 11;
  localparam int S_SHIFT_EMPTY = 0;
  localparam int S_TXBUF_EMPTY = 1;
  localparam int S_RX_PEND = 2;
  localparam int S_FRAMING_ERROR_FLAG = 3;
  localparam int S_OVR = 4;
  localparam int S_RX_NINTH_BIT = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [15:0] BAUD_RST = 16'h0003;
  localparam logic [3:0] BREAK_BITS = 4'hE;
  localparam logic [3:0] ASYNC_BITS8 = 4'hA;
  localparam logic [3:0] ASYNC_BITS9 = 4'hB;
  localparam logic [3:0] SYNC_BITS8 = 4'h8;
  localparam logic [3:0] SYNC_BITS9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} ubs_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} ubs_rx_e;
endpackage

/* rtl/ubs_top.sv */
// Break generator/detector and synchronous serial port with APB registers
`timescale 1ns/10ps
`default_nettype none
module ubs_top
  import ubs_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pin
  input wire logic clock_pin_in,
  output logic clock_pin_out,
  output logic clock_pin_oe,
  // Data pin
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe
);
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [15:0] baud_ff;
  logic [15:0] bcnt_ff, rx_bcnt_ff;
  logic [31:0] prdata_ff;
  logic hold_full_ff, brk_ff, tx_sub_ff, dout_ff, phase_ff, clk_pin_ff;
  logic [7:0] hold_ff;
  logic [13:0] tx_sr_ff;
  logic [3:0] tx_left_ff, rx_left_ff;
  logic [8:0] rx_sr_ff;
  logic rx_sub_ff, ovr_ff, wake_pend_ff, cont_q_ff;
  logic [9:0] fifo_mem [2];
  logic fifo_rd_ff, fifo_wr_ff;
  logic [1:0] fifo_cnt_ff;
  logic clk_s1_ff, clk_s2_ff, clk_s3_ff, dat_s1_ff, dat_s2_ff, dat_s3_ff;
  ubs_tx_e tx_st_ff;
  ubs_rx_e rx_st_ff;

  logic pen, sync_m, master, rx_mode, pol, rx9, tx9;
  logic wr_en, rd_en, addr_ok, rd_rx, wr_tx, wr_ctrl;
  logic half_tick, rx_tick, running, lead_ev, trail_ev;
  logic tx_go, brk_done, rx_push, rx_framing_error_flag, wake_rise;
  logic dat_fall, dat_rise;
  logic [8:0] rx_word;
  logic [9:0] fifo_top;

  assign pen = ctrl_ff[B_PEN];
  assign sync_m = ctrl_ff[B_SYNC];
  assign master = ctrl_ff[B_MASTER];
  // Either receive enable selects receive direction
  assign rx_mode = ctrl_ff[B_SINGLE] | ctrl_ff[B_CONT];
  assign pol = ctrl_ff[B_POL];
  assign rx9 = ctrl_ff[B_RX9];
  assign tx9 = ctrl_ff[B_TX9];

  // APB decode; zero wait states
  assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_TXDATA) ||
                   (paddr == OFS_RXDATA) || (paddr == OFS_BAUD);
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_en = psel & penable & ~pwrite & addr_ok;
  assign wr_ctrl = wr_en & (paddr == OFS_CTRL);
  assign wr_tx = wr_en & (paddr == OFS_TXDATA);
  assign rd_rx = rd_en & (paddr == OFS_RXDATA);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_ff;

  // Link pins pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      dat_s1_ff <= 1'b1;
      dat_s2_ff <= 1'b1;
      dat_s3_ff <= 1'b1;
    end else begin
      clk_s1_ff <= clock_pin_in;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      dat_s1_ff <= data_pin_in;
      dat_s2_ff <= dat_s1_ff;
      dat_s3_ff <= dat_s2_ff;
    end
  end
  assign dat_fall = dat_s3_ff & ~dat_s2_ff;
  assign dat_rise = ~dat_s3_ff & dat_s2_ff;

  assign fifo_top = fifo_mem[fifo_rd_ff];

  // Read data captured in the setup phase; pop happens at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      unique case (paddr)
        OFS_CTRL: prdata_ff[CTRL_W-1:0] <= ctrl_ff;
        OFS_STATUS: begin
          prdata_ff[S_SHIFT_EMPTY] <= (tx_st_ff == TX_IDLE);
          prdata_ff[S_TXBUF_EMPTY] <= ~hold_full_ff;
          prdata_ff[S_RX_PEND] <= (fifo_cnt_ff != 2'h0) | wake_pend_ff;
          prdata_ff[S_FRAMING_ERROR_FLAG] <= (fifo_cnt_ff != 2'h0) & fifo_top[9];
          prdata_ff[S_OVR] <= ovr_ff;
          prdata_ff[S_RX_NINTH_BIT] <= (fifo_cnt_ff != 2'h0) & fifo_top[8];
        end
        // Empty FIFO reads zero, which is also what a wake event returns
        OFS_RXDATA: prdata_ff[7:0] <= (fifo_cnt_ff != 2'h0) ? fifo_top[7:0] : 8'h00;
        OFS_BAUD: prdata_ff[15:0] <= baud_ff;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Control register with hardware self-clearing bits
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = pwdata[CTRL_W-1:0];
    end
    if (brk_done) begin
      nxt_ctrl[B_SEND_BREAK_REQ] = 1'b0;
    end
    if (rx_push && sync_m) begin
      nxt_ctrl[B_SINGLE] = 1'b0;
    end
    if (wake_rise) begin
      nxt_ctrl[B_WAKE] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      cont_q_ff <= 1'b0;
      baud_ff <= BAUD_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cont_q_ff <= ctrl_ff[B_CONT];
      if (wr_en && paddr == OFS_BAUD) begin
        baud_ff <= pwdata[15:0];
      end
    end
  end

  // Half-bit enables: one for transmit and master clock, one restarted by each start bit
  assign half_tick = (bcnt_ff == baud_ff);
  assign rx_tick = (rx_bcnt_ff == baud_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_ff <= 16'h0000;
      rx_bcnt_ff <= 16'h0000;
    end else begin
      bcnt_ff <= half_tick ? 16'h0000 : bcnt_ff + 16'h0001;
      if (rx_tick || (rx_st_ff == RX_IDLE && dat_fall)) begin
        rx_bcnt_ff <= 16'h0000;
      end else begin
        rx_bcnt_ff <= rx_bcnt_ff + 16'h0001;
      end
    end
  end

  // Master clock runs only while a character moves
  // Receive enables gate the clock too, so clearing them cuts it in the same cycle
  assign running = pen & sync_m & master &
                   (tx_st_ff == TX_SYNC || (rx_st_ff == RX_SYNC && rx_mode));
  always_comb begin
    if (master) begin
      lead_ev = running & half_tick & ~phase_ff;
      trail_ev = running & half_tick & phase_ff;
    end else begin
      lead_ev = (clk_s3_ff == pol) & (clk_s2_ff != pol);
      trail_ev = (clk_s3_ff != pol) & (clk_s2_ff == pol);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 1'b0;
    end else if (!running) begin
      phase_ff <= 1'b0;
    end else if (half_tick) begin
      phase_ff <= ~phase_ff;
    end
  end

  // Holding register feeds the shifter as soon as it is empty
  assign tx_go = pen & ctrl_ff[B_TRANSMIT_ENABLE_BIT] & hold_full_ff & (tx_st_ff == TX_IDLE) &
                 (~sync_m | (~rx_mode & rx_st_ff == RX_IDLE));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_full_ff <= 1'b0;
      hold_ff <= 8'h00;
    end else if (!pen) begin
      hold_full_ff <= 1'b0;
    end else if (wr_tx) begin
      hold_full_ff <= 1'b1;
      hold_ff <= pwdata[7:0];
    end else if (tx_go) begin
      hold_full_ff <= 1'b0;
    end
  end

  assign brk_done = (tx_st_ff == TX_ASYNC) & brk_ff & half_tick & tx_sub_ff & (tx_left_ff == 4'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff <= TX_IDLE;
      tx_sr_ff <= 14'h3FFF;
      tx_left_ff <= 4'h0;
      tx_sub_ff <= 1'b0;
      brk_ff <= 1'b0;
      dout_ff <= 1'b1;
    end else if (!pen) begin
      tx_st_ff <= TX_IDLE;
      tx_sr_ff <= 14'h3FFF;
      brk_ff <= 1'b0;
    end else begin
      unique case (tx_st_ff)
        TX_IDLE: begin
          tx_sub_ff <= 1'b0;
          if (tx_go && !sync_m) begin
            tx_st_ff <= TX_ASYNC;
            brk_ff <= ctrl_ff[B_SEND_BREAK_REQ];
            if (ctrl_ff[B_SEND_BREAK_REQ]) begin
              // Written value ignored: start, twelve zeros, stop
              tx_sr_ff <= {1'b1, 13'h0000};
              tx_left_ff <= BREAK_BITS;
            end else begin
              tx_sr_ff <= {4'hF, tx9 ? ctrl_ff[B_TX_NINTH_BIT] : 1'b1, hold_ff, 1'b0};
              tx_left_ff <= tx9 ? ASYNC_BITS9 : ASYNC_BITS8;
            end
          end else if (tx_go) begin
            // No framing bits in synchronous mode
            tx_st_ff <= TX_SYNC;
            tx_sr_ff <= {5'h00, ctrl_ff[B_TX_NINTH_BIT], hold_ff};
            tx_left_ff <= tx9 ? SYNC_BITS9 : SYNC_BITS8;
          end
        end
        TX_ASYNC: begin
          if (half_tick) begin
            tx_sub_ff <= ~tx_sub_ff;
            if (tx_sub_ff) begin
              tx_sr_ff <= {1'b1, tx_sr_ff[13:1]};
              tx_left_ff <= tx_left_ff - 4'h1;
              if (tx_left_ff == 4'h1) begin
                tx_st_ff <= TX_IDLE;
                brk_ff <= 1'b0;
              end
            end
          end
        end
        TX_SYNC: begin
          if (!sync_m) begin
            tx_st_ff <= TX_IDLE;
          end else if (lead_ev) begin
            dout_ff <= tx_sr_ff[0];
            tx_sr_ff <= {1'b0, tx_sr_ff[13:1]};
          end else if (trail_ev) begin
            tx_left_ff <= tx_left_ff - 4'h1;
            if (tx_left_ff == 4'h1) begin
              tx_st_ff <= TX_IDLE;
            end
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // Receiver: async with framing check, or synchronous on trailing edges
  always_comb begin
    rx_push = 1'b0;
    rx_framing_error_flag = 1'b0;
    rx_word = 9'h000;
    if (rx_st_ff == RX_ASYNC && rx_tick && !rx_sub_ff && rx_left_ff == 4'h1) begin
      rx_push = 1'b1;
      rx_framing_error_flag = ~dat_s2_ff;
      rx_word = rx9 ? rx_sr_ff : {1'b0, rx_sr_ff[8:1]};
    end else if (rx_st_ff == RX_SYNC && trail_ev && rx_left_ff == 4'h1) begin
      rx_push = 1'b1;
      rx_word = rx9 ? {dat_s2_ff, rx_sr_ff[8:1]} : {1'b0, dat_s2_ff, rx_sr_ff[8:2]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff <= RX_IDLE;
      rx_sr_ff <= 9'h000;
      rx_left_ff <= 4'h0;
      rx_sub_ff <= 1'b0;
    end else if (!pen) begin
      rx_st_ff <= RX_IDLE;
    end else begin
      unique case (rx_st_ff)
        RX_IDLE: begin
          rx_sub_ff <= 1'b0;
          if (!sync_m && ctrl_ff[B_CONT] && !ovr_ff && !ctrl_ff[B_WAKE] && dat_fall) begin
            rx_st_ff <= RX_ASYNC;
            rx_left_ff <= rx9 ? ASYNC_BITS9 : ASYNC_BITS8;
          end else if (sync_m && rx_mode && !ovr_ff && tx_st_ff == TX_IDLE) begin
            rx_st_ff <= RX_SYNC;
            rx_left_ff <= rx9 ? SYNC_BITS9 : SYNC_BITS8;
          end
        end
        RX_ASYNC: begin
          if (rx_tick) begin
            rx_sub_ff <= ~rx_sub_ff;
            if (!rx_sub_ff) begin
              rx_left_ff <= rx_left_ff - 4'h1;
              if (rx_left_ff == (rx9 ? ASYNC_BITS9 : ASYNC_BITS8)) begin
                if (dat_s2_ff) begin
                  rx_st_ff <= RX_IDLE;
                end
              end else if (rx_left_ff == 4'h1) begin
                rx_st_ff <= RX_IDLE;
              end else begin
                rx_sr_ff <= {dat_s2_ff, rx_sr_ff[8:1]};
              end
            end
          end
        end
        RX_SYNC: begin
          if (!sync_m || !rx_mode) begin
            rx_st_ff <= RX_IDLE;
          end else if (trail_ev) begin
            rx_sr_ff <= {dat_s2_ff, rx_sr_ff[8:1]};
            rx_left_ff <= rx_left_ff - 4'h1;
            if (rx_left_ff == 4'h1) begin
              rx_st_ff <= RX_IDLE;
            end
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // Two-entry FIFO; a read pops the oldest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_rd_ff <= 1'b0;
      fifo_wr_ff <= 1'b0;
      fifo_cnt_ff <= 2'h0;
      fifo_mem[0] <= 10'h000;
      fifo_mem[1] <= 10'h000;
    end else if (!pen) begin
      fifo_rd_ff <= 1'b0;
      fifo_wr_ff <= 1'b0;
      fifo_cnt_ff <= 2'h0;
    end else begin
      if (rx_push && fifo_cnt_ff != FIFO_DEPTH) begin
        fifo_mem[fifo_wr_ff] <= {rx_framing_error_flag, rx_word};
        fifo_wr_ff <= ~fifo_wr_ff;
      end
      if (rd_rx && fifo_cnt_ff != 2'h0) begin
        fifo_rd_ff <= ~fifo_rd_ff;
      end
      fifo_cnt_ff <= fifo_cnt_ff + {1'b0, rx_push && fifo_cnt_ff != FIFO_DEPTH}
                     - {1'b0, rd_rx && fifo_cnt_ff != 2'h0};
    end
  end

  // Overrun: contents kept, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_ff <= 1'b0;
    end else if (rx_push && fifo_cnt_ff == FIFO_DEPTH) begin
      ovr_ff <= 1'b1;
    end else if (!pen || (cont_q_ff && !ctrl_ff[B_CONT]) || (rd_rx && !ctrl_ff[B_CONT])) begin
      ovr_ff <= 1'b0;
    end
  end

  // Wake-up: falling edge flags pending, rising edge ends the break
  assign wake_rise = ctrl_ff[B_WAKE] & wake_pend_ff & dat_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pend_ff <= 1'b0;
    end else if (pen && !sync_m && ctrl_ff[B_WAKE] && rx_st_ff == RX_IDLE && dat_fall) begin
      wake_pend_ff <= 1'b1;
    end else if (rd_rx || !pen) begin
      wake_pend_ff <= 1'b0;
    end
  end

  // Pin drivers; async line idles high on the clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_pin_ff <= 1'b1;
    end else if (sync_m) begin
      clk_pin_ff <= pol ^ (phase_ff & running);
    end else begin
      clk_pin_ff <= (tx_st_ff == TX_ASYNC) ? tx_sr_ff[0] : 1'b1;
    end
  end
  assign clock_pin_out = clk_pin_ff;
  assign clock_pin_oe = pen & (sync_m ? master : ctrl_ff[B_TRANSMIT_ENABLE_BIT]);
  assign data_pin_out = dout_ff;
  assign data_pin_oe = pen & sync_m & ~rx_mode & ctrl_ff[B_TRANSMIT_ENABLE_BIT];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_break_zeros: assert property ((tx_st_ff == TX_ASYNC && brk_ff && tx_left_ff != 4'h1)
    |-> !tx_sr_ff[0]) else $error("break bit not zero");
  a_break_clear: assert property (brk_done |=> !ctrl_ff[B_SEND_BREAK_REQ] && tx_st_ff == TX_IDLE)
    else $error("break request not cleared");
  a_half_duplex: assert property (!(tx_st_ff == TX_SYNC && rx_st_ff == RX_SYNC))
    else $error("sync transmit and receive together");
  a_master_clk: assert property (pen && sync_m && master |-> clock_pin_oe)
    else $error("master clock driver off");
  a_data_lead: assert property (!$stable(dout_ff) |-> $past(lead_ev))
    else $error("data changed off leading edge");
  a_clk_idle: assert property ((sync_m && !running)[*2] |-> clock_pin_out == pol)
    else $error("clock not at idle level");
  a_rx_release: assert property (sync_m && rx_mode |-> !data_pin_oe)
    else $error("data driven during receive");
  a_single_once: assert property (rx_push && sync_m |=> !ctrl_ff[B_SINGLE])
    else $error("single receive not cleared");
  a_cont_abort: assert property (rx_st_ff == RX_SYNC && !rx_mode |=> rx_st_ff == RX_IDLE)
    else $error("reception not aborted");
  a_ovr_keep: assert property (rx_push && fifo_cnt_ff == FIFO_DEPTH && !rd_rx
    |=> ovr_ff && fifo_cnt_ff == FIFO_DEPTH) else $error("overrun handling wrong");
  a_pop_order: assert property (rd_rx && fifo_cnt_ff == 2'h2 && !rx_push
    |=> fifo_cnt_ff == 2'h1) else $error("fifo pop wrong");

  c_break_sent: cover property (brk_done);
  c_overrun: cover property (rx_push && fifo_cnt_ff == FIFO_DEPTH);
  c_sync_rx: cover property (rx_push && sync_m && master);
  c_wake: cover property (wake_rise);
endmodule
`default_nettype wire

/* sim/test_usart_break_and_sync_serial.sv */
// Self-checking bench for the break and synchronous serial block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_usart_break_and_sync_serial;
  import ubs_pkg::*;
  localparam logic [31:0] PEN = 32'h1 << B_PEN;
  localparam logic [31:0] SYN = 32'h1 << B_SYNC;
  localparam logic [31:0] MST = 32'h1 << B_MASTER;
  localparam logic [31:0] TXE = 32'h1 << B_TRANSMIT_ENABLE_BIT;
  localparam logic [31:0] SNB = 32'h1 << B_SEND_BREAK_REQ;
  localparam logic [31:0] SGL = 32'h1 << B_SINGLE;
  localparam logic [31:0] CNT = 32'h1 << B_CONT;
  localparam logic [31:0] POL = 32'h1 << B_POL;
  localparam logic [31:0] R9 = 32'h1 << B_RX9;
  localparam logic [31:0] WK = 32'h1 << B_WAKE;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pol, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic clock_pin_out, clock_pin_oe, data_pin_out, data_pin_oe;
  logic ck_drv, ck_oe, dt_drv, dt_oe;
  int fails, n_tests;
  // Both lines carry pull-ups
  wire logic ck_line = clock_pin_oe ? clock_pin_out : (ck_oe ? ck_drv : 1'b1);
  wire logic dt_line = data_pin_oe ? data_pin_out : (dt_oe ? dt_drv : 1'b1);
  ubs_top ubs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_pin_in(ck_line), .clock_pin_out(clock_pin_out),
    .clock_pin_oe(clock_pin_oe), .data_pin_in(dt_line), .data_pin_out(data_pin_out),
    .data_pin_oe(data_pin_oe));
  ubs_sync_peer peer_inst (.clock_line(ck_line), .data_line(dt_line), .pol(pol),
    .ck_drv(ck_drv), .ck_oe(ck_oe), .dt_drv(dt_drv), .dt_oe(dt_oe));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic results();
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bail();
    fails++;
    results();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) bail();
  endtask
  task automatic wait_st(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < 100);
    if (k >= 100) bail();
  endtask
  task automatic wait_lead(input int n);
    int k;
    k = 0;
    while (peer_inst.n_lead < n && k < 1000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 1000) bail();
  endtask
  // Async frame on the transmit line, bits LSB first, sampled mid-bit (8 cycles a bit)
  task automatic frame(input int nb, input logic [15:0] exp);
    int k;
    k = 0;
    while (clock_pin_out !== 1'b0 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) bail();
    for (int i = 0; i < nb; i++) begin
      repeat (i == 0 ? 4 : 8) @(posedge pclk);
      `CHK(clock_pin_out, exp[i])
    end
  endtask
  task automatic t_reset();
    `CHK({clock_pin_oe, data_pin_oe}, 2'b00)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, OFS_BAUD, 32'h0);
    `CHK(rd, 32'h0000_0003)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
  endtask
  task automatic t_break();
    apb(1'b1, OFS_CTRL, PEN | TXE | SNB);
    fork
      frame(14, 16'h2000);
      begin
        apb(1'b1, OFS_TXDATA, 32'h0000_00A5);
        apb(1'b1, OFS_TXDATA, 32'h0000_0055);
      end
    join
    frame(10, 16'h02AA);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[B_SEND_BREAK_REQ], 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  task automatic t_mtx(input logic p);
    pol = p;
    apb(1'b1, OFS_CTRL, PEN | SYN | MST | TXE | (p ? POL : 32'h0));
    repeat (4) @(posedge pclk);
    `CHK(clock_pin_out, p)
    peer_inst.arm(9'h000, 9, 1'b0);
    apb(1'b1, OFS_TXDATA, 32'h0000_003C);
    apb(1'b1, OFS_TXDATA, 32'h0000_00D2);
    wait_lead(16);
    repeat (20) @(posedge pclk);
    `CHK(peer_inst.n_lead, 16)
    `CHK(peer_inst.rx_word[15:0], 16'hD23C)
    `CHK({clock_pin_oe, data_pin_oe, clock_pin_out}, {2'b11, p})
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  task automatic t_srx();
    pol = 1'b0;
    apb(1'b1, OFS_CTRL, PEN | SYN | MST | R9);
    peer_inst.arm(9'h1A5, 9, 1'b1);
    apb(1'b1, OFS_CTRL, PEN | SYN | MST | R9 | SGL);
    `CHK(data_pin_oe, 1'b0)
    wait_st(S_RX_PEND);
    repeat (40) @(posedge pclk);
    `CHK(peer_inst.n_lead, 9)
    `CHK(rd[S_RX_NINTH_BIT], 1'b1)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[B_SINGLE], 1'b0)
    apb(1'b0, OFS_RXDATA, 32'h0);
    `CHK(rd, 32'h0000_00A5)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[S_RX_PEND], 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  task automatic t_over();
    apb(1'b1, OFS_CTRL, PEN | SYN | MST);
    peer_inst.arm(9'h030, 8, 1'b1);
    apb(1'b1, OFS_CTRL, PEN | SYN | MST | CNT);
    wait_st(S_OVR);
    `CHK(rd[S_RX_PEND], 1'b1)
    apb(1'b0, OFS_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h30)
    apb(1'b0, OFS_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h31)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[S_OVR:S_RX_PEND], 3'b100)
    apb(1'b1, OFS_CTRL, PEN | SYN | MST);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[S_OVR], 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  task automatic t_abort();
    int n;
    apb(1'b1, OFS_CTRL, PEN | SYN | MST);
    peer_inst.arm(9'h05A, 8, 1'b1);
    apb(1'b1, OFS_CTRL, PEN | SYN | MST | SGL | CNT);
    wait_lead(10);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[B_CONT:B_SINGLE], 2'b10)
    apb(1'b1, OFS_CTRL, PEN | SYN | MST);
    repeat (2) @(posedge pclk);
    n = peer_inst.n_lead;
    repeat (40) @(posedge pclk);
    `CHK(peer_inst.n_lead, n)
    apb(1'b0, OFS_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h5A)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[S_RX_PEND], 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  // Idle-high clock so the pull-up makes no stray edge between frames
  task automatic t_slave();
    pol = 1'b1;
    apb(1'b1, OFS_CTRL, PEN | SYN | CNT | POL);
    peer_inst.arm(9'h096, 8, 1'b1);
    #37;
    peer_inst.clock_out(8);
    `CHK(clock_pin_oe, 1'b0)
    wait_st(S_RX_PEND);
    apb(1'b0, OFS_RXDATA, 32'h0);
    `CHK(rd[7:0], 8'h96)
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  task automatic t_rxbrk();
    apb(1'b1, OFS_CTRL, PEN | CNT);
    #37;
    peer_inst.line_low(10400);
    wait_st(S_RX_PEND);
    `CHK(rd[S_FRAMING_ERROR_FLAG], 1'b1)
    apb(1'b0, OFS_RXDATA, 32'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  task automatic t_wake();
    apb(1'b1, OFS_CTRL, PEN | CNT | WK);
    #37;
    peer_inst.line_low(10400);
    wait_st(S_RX_PEND);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[B_WAKE], 1'b0)
    apb(1'b0, OFS_RXDATA, 32'h0);
    `CHK(rd, 32'h0000_0000)
    // Start bit and bit 0 low, the rest high: the byte after the break is FE
    #37;
    peer_inst.line_low(1600);
    wait_st(S_RX_PEND);
    apb(1'b0, OFS_RXDATA, 32'h0);
    `CHK(rd, 32'h0000_00FE)
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pol = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_break();
    t_mtx(1'b0);
    t_mtx(1'b1);
    t_srx();
    t_over();
    t_abort();
    t_slave();
    t_rxbrk();
    t_wake();
    results();
  end
endmodule
`default_nettype wire

/* sim/ubs_sync_peer.sv */
// Far-end synchronous serial device that drives and watches the two link lines
`timescale 1ns/10ps
`default_nettype none
module ubs_sync_peer (
  // Lines as seen on the wire, and the clock idle level
  input wire logic clock_line,
  input wire logic data_line,
  input wire logic pol,
  // Drives onto the wire
  output logic ck_drv,
  output logic ck_oe,
  output logic dt_drv,
  output logic dt_oe
);
  logic [8:0] tx_word;
  logic [17:0] rx_word;
  int nb;
  int tx_idx;
  int rx_cnt;
  int n_lead;
  initial begin
    ck_drv = 1'b1;
    ck_oe = 1'b0;
    dt_drv = 1'b1;
    dt_oe = 1'b0;
    rx_word = 18'h00000;
  end
  task automatic arm(input logic [8:0] w, input int n, input logic drive);
    tx_word = w;
    nb = n;
    tx_idx = 0;
    rx_cnt = 0;
    n_lead = 0;
    dt_oe = drive;
  endtask
  // Each later character is one higher, so buffered entries can be told apart
  always @(clock_line) begin
    if (clock_line !== pol) begin
      n_lead++;
      if (dt_oe) begin
        dt_drv = tx_word[tx_idx];
        tx_idx++;
        if (tx_idx == nb) begin
          tx_idx = 0;
          tx_word = tx_word + 9'h001;
        end
      end
    end else if (rx_cnt < 18) begin
      rx_word[rx_cnt] = data_line;
      rx_cnt++;
    end
  end
  // Clock only as many cycles as bits, and let the line go back to its pull-up after
  task automatic clock_out(input int n);
    ck_drv = pol;
    ck_oe = 1'b1;
    repeat (n) begin
      #400 ck_drv = ~pol;
      #400 ck_drv = pol;
    end
    #400 ck_oe = 1'b0;
  endtask
  task automatic line_low(input int t);
    dt_oe = 1'b1;
    dt_drv = 1'b0;
    #t dt_drv = 1'b1;
    #800 dt_oe = 1'b0;
  endtask
endmodule
`default_nettype wire
